/* File: hw/mid_pkg.sv */
// Purpose: shared constants and types of the instruction decoder core
// Assumes: 14-bit instruction words, 8-bit data, 128-byte file space
// Notes:   every encoding and address is named here once
package mid_pkg;
	// ****************************************************
	// widths and timing
	// ****************************************************
	localparam int PC_W    = 13;
	localparam int TGT_W   = 11;
	localparam int INSN_W  = 14;
	localparam int FADDR_W = 7;
	localparam int FILES   = 128;
	localparam int STACK_D = 8;
	localparam int OSC_PER_CYCLE = 4;  // oscillator periods per instruction cycle
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
	// ****************************************************
	// file register map and status layout
	// ****************************************************
	localparam logic [6:0] F_TIMER  = 7'h01;
	localparam logic [6:0] F_STATUS = 7'h03;
	localparam logic [6:0] F_PORT   = 7'h06;
	localparam logic [6:0] F_PCLATH = 7'h0A;
	localparam logic [6:0] F_INTCON = 7'h0B;
	localparam int ST_C = 0, ST_DC = 1, ST_Z = 2, ST_PD = 3, ST_TO = 4, GIE_BIT = 7;
	localparam int PCLATH_LO = 3;
	localparam logic [7:0] STATUS_RST = 8'h18;
	// ****************************************************
	// instruction encodings
	// ****************************************************
	localparam logic [1:0] CL_BYTE = 2'h0, CL_BIT = 2'h1, CL_JUMP = 2'h2, CL_LIT = 2'h3;
	localparam logic [3:0] N_MOVWF = 4'h0, N_CLR = 4'h1, N_SUB = 4'h2, N_DEC = 4'h3;
	localparam logic [3:0] N_IOR = 4'h4, N_AND = 4'h5, N_XOR = 4'h6, N_ADD = 4'h7;
	localparam logic [3:0] N_MOVF = 4'h8, N_COM = 4'h9, N_INC = 4'hA, N_DECSZ = 4'hB;
	localparam logic [3:0] N_RRC = 4'hC, N_RLC = 4'hD, N_SWAP = 4'hE, N_INCSZ = 4'hF;
	localparam logic [1:0] B_CLR = 2'h0, B_SET = 2'h1, B_TSTC = 2'h2, B_TSTS = 2'h3;
	localparam logic [1:0] L_MOVE = 2'h0, L_RET = 2'h1;
	localparam logic [3:0] L_IOR = 4'h8, L_AND = 4'h9, L_XOR = 4'hA;
	localparam logic [2:0] L_SUB = 3'h6, L_ADD = 3'h7;
	localparam logic [13:0] OP_RETURN = 14'h0008, OP_INTERRUPT_RETURN = 14'h0009;
	localparam logic [13:0] OP_WATCHDOG_CLEAR_OP = 14'h0064, OP_SLEEP = 14'h0063;
	// ****************************************************
	// apb register map
	// ****************************************************
	localparam logic [7:0] A_CTRL = 8'h00, A_STATE = 8'h04, A_PORT = 8'h08;
	localparam int C_RUN = 0, C_PSA = 1, C_WAKE = 2;
	localparam logic [2:0] CTRL_RST = 3'h1;
	typedef enum logic [3:0] {
		MID_PASS_B, MID_PASS_A, MID_CLR, MID_ADD, MID_SUB, MID_AND, MID_OR, MID_XOR,
		MID_COM, MID_INC, MID_DEC, MID_RLC, MID_RRC, MID_SWAP, MID_BCLR, MID_BSET
	} mid_op_t;
endpackage

/* File: hw/mid_alu_if.sv */
// Purpose: operand and result bundle between core and data path
// Assumes: purely combinational data path
// Notes:   none
`timescale 1ns/1ps
interface mid_alu_if;
	import mid_pkg::*;
	mid_op_t    op;
	logic [7:0] a;      // working register
	logic [7:0] b;      // file value or literal
	logic [2:0] bsel;
	logic       cin;
	logic [7:0] res;
	logic       c;
	logic       dc;
	modport alu (input op, a, b, bsel, cin, output res, c, dc);
	modport core (output op, a, b, bsel, cin, input res, c, dc);
endinterface

/* File: hw/mid_alu.sv */
// Purpose: 8-bit data path for byte, bit and literal operations
// Assumes: carry is the inverse of borrow on subtraction
// Notes:   zero flag is formed by the caller from res
`timescale 1ns/1ps
module mid_alu import mid_pkg::*; (
	mid_alu_if.alu x
);
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] mask;
	// ****************************************************
	// arithmetic and logic
	// ****************************************************
	// subtraction reuses the adder with an inverted a; carry means no borrow
	always_comb begin
		mask = 8'h01 << x.bsel;
		sum  = '0;
		half = '0;
		x.res = x.b;
		x.c   = x.cin;
		x.dc  = 1'b0;
		unique case (x.op)
			MID_PASS_B: x.res = x.b;
			MID_PASS_A: x.res = x.a;
			MID_CLR:    x.res = 8'h00;
			MID_ADD, MID_SUB: begin
				if (x.op == MID_ADD) begin
					sum  = {1'b0, x.b} + {1'b0, x.a};
					half = {1'b0, x.b[3:0]} + {1'b0, x.a[3:0]};
				end else begin
					sum  = {1'b0, x.b} + {1'b0, ~x.a} + 9'h001;
					half = {1'b0, x.b[3:0]} + {1'b0, ~x.a[3:0]} + 5'h01;
				end
				x.res = sum[7:0];
				x.c   = sum[8];
				x.dc  = half[4];
			end
			MID_AND:  x.res = x.a & x.b;
			MID_OR:   x.res = x.a | x.b;
			MID_XOR:  x.res = x.a ^ x.b;
			MID_COM:  x.res = ~x.b;
			MID_INC:  x.res = x.b + 8'h01;
			MID_DEC:  x.res = x.b - 8'h01;
			MID_RLC: begin
				x.res = {x.b[6:0], x.cin};  // carry fills the vacated bit
				x.c   = x.b[7];
			end
			MID_RRC: begin
				x.res = {x.cin, x.b[7:1]};
				x.c   = x.b[0];
			end
			MID_SWAP: x.res = {x.b[3:0], x.b[7:4]};
			MID_BCLR: x.res = x.b & ~mask;
			MID_BSET: x.res = x.b | mask;
		endcase
	end
endmodule // mid_alu

/* File: hw/mid_stack.sv */
// Purpose: circular return address stack
// Assumes: push and pop never in the same cycle
// Notes:   overflow silently wraps, as on the real core
`timescale 1ns/1ps
module mid_stack import mid_pkg::*; #(
	parameter int DEPTH = STACK_D
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            push,
	input  wire logic            pop,
	input  wire logic [PC_W-1:0] din,
	output logic      [PC_W-1:0] top
);
	logic [PC_W-1:0]          mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] sp_r;
	// ****************************************************
	// pointer and storage
	// ****************************************************
	// sp_r points at the next free slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_r <= '0;
		end else if (push) begin
			mem[sp_r] <= din;
			sp_r      <= sp_r + 1'b1;
		end else if (pop) begin
			sp_r <= sp_r - 1'b1;
		end
	end
	assign top = mem[sp_r - 1'b1];
endmodule // mid_stack

/* File: hw/mid_core.sv */
// Purpose: decode and execute of 14-bit instructions, with apb control
// Assumes: prog_data is valid for the word at prog_addr by the cycle end
// Notes:   one instruction cycle is four pclk periods
//
// Summary of operation
// - or/and/xor with file, zero only
// - rotates through carry, carry only
// - inc/dec skip on zero, no flags
// - clear or set one file bit
// - bit test skips on clear or set
// - skip discards fetched word as no-op
// - branch or true test takes two cycles
// - port read-modify-write uses pin levels
// - timer write clears assigned prescaler
// - return, call, jump with 11-bit target
// - interrupt return pops and sets enable
// - return with literal loads accumulator
// - watchdog clear sets timeout and powerdown
// - standby entry, timeout set, powerdown cleared
// - literal or/and/xor, zero only
// - literal add/sub full flags, move none
// - destination bit picks accumulator or file
// - four periods per cycle, one cycle
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module mid_core import mid_pkg::*; #(
	parameter int AW = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [AW-1:0]     paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [PC_W-1:0]   prog_addr,
	input  wire logic [INSN_W-1:0] prog_data,
	input  wire logic [7:0]        port_pins,
	output logic      [7:0]        port_latch,
	output logic                   prescaler_clear,
	output logic                   watchdog_clear,
	output logic                   standby,
	output logic                   gie
);
	mid_alu_if     ax ();
	logic [7:0]    fmem [FILES];
	logic [PC_W-1:0] pc_r;
	logic [INSN_W-1:0] ir_r;
	logic          flush_r;
	logic [1:0]    phase_r;
	logic [7:0]    w_r;
	logic [7:0]    status_r;
	logic [7:0]    status_nxt;
	logic [2:0]    ctrl_r;
	logic          sleep_r;
	logic [PC_W-1:0] stack_top;
	logic          exec;
	logic          kill;
	logic [6:0]    fa;
	logic [7:0]    fval;
	logic [1:0]    cls;
	logic [3:0]    nib;
	// decoded controls
	logic          wr_w, wr_f, upd_z, upd_c, upd_dc;
	logic          skip, jump, push, pop, set_gie, watchdog_clear_op, sleep_op;
	logic [PC_W-1:0] tgt;
	logic          acc_ok, is_wr, bad;

	// ****************************************************
	// sub-blocks
	// ****************************************************
	mid_alu u_alu (
		.x (ax.alu)
	);
	mid_stack #(.DEPTH(STACK_D)) u_stack (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (exec && !kill && push),
		.pop     (exec && !kill && pop),
		.din     (pc_r),
		.top     (stack_top)
	);

	// ****************************************************
	// instruction cycle timing
	// ****************************************************
	// execute once per four pclk periods, only when running and awake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= '0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end
	assign exec = (phase_r == PHASE_LAST) && ctrl_r[C_RUN] && !sleep_r;
	assign kill = flush_r;  // fetched word runs as a no-operation

	// ****************************************************
	// operand fetch
	// ****************************************************
	assign cls = ir_r[13:12];
	assign nib = ir_r[11:8];
	assign fa  = ir_r[6:0];
	// the port address returns pin levels, never the latch, so any
	// modify-and-write-back of the port writes the pins back
	always_comb begin
		unique case (fa)
			F_STATUS: fval = status_r;
			F_PORT:   fval = port_pins;
			default:  fval = fmem[fa];
		endcase
	end

	// ****************************************************
	// decode
	// ****************************************************
	always_comb begin
		ax.op   = MID_PASS_B;
		ax.a    = w_r;
		ax.b    = fval;
		ax.bsel = ir_r[9:7];
		ax.cin  = status_r[ST_C];
		wr_w = 1'b0;
		wr_f = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		skip = 1'b0;
		jump = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		set_gie = 1'b0;
		watchdog_clear_op = 1'b0;
		sleep_op = 1'b0;
		tgt = {fmem[F_PCLATH][PCLATH_LO+1:PCLATH_LO], ir_r[TGT_W-1:0]};
		unique case (cls)
			CL_BYTE: begin
				wr_w = !ir_r[7];
				wr_f = ir_r[7];
				unique case (nib)
					N_MOVWF: begin
						wr_w = 1'b0;
						wr_f = ir_r[7];
						ax.op = MID_PASS_A;
						if (!ir_r[7]) begin
							if (ir_r == OP_RETURN) begin
								pop  = 1'b1;
								jump = 1'b1;
							end
							if (ir_r == OP_INTERRUPT_RETURN) begin
								pop     = 1'b1;
								jump    = 1'b1;
								set_gie = 1'b1;
							end
							watchdog_clear_op   = (ir_r == OP_WATCHDOG_CLEAR_OP);
							sleep_op = (ir_r == OP_SLEEP);
						end
					end
					N_CLR: begin
						ax.op = MID_CLR;
						upd_z = 1'b1;
					end
					N_SUB, N_ADD: begin
						ax.op  = (nib == N_ADD) ? MID_ADD : MID_SUB;
						upd_z  = 1'b1;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					N_IOR, N_AND, N_XOR: begin
						ax.op = (nib == N_IOR) ? MID_OR :
							(nib == N_AND) ? MID_AND : MID_XOR;
						upd_z = 1'b1;
					end
					N_DEC, N_INC, N_MOVF, N_COM: begin
						ax.op = (nib == N_DEC) ? MID_DEC : (nib == N_INC) ? MID_INC :
							(nib == N_COM) ? MID_COM : MID_PASS_B;
						upd_z = 1'b1;
					end
					N_INCSZ, N_DECSZ: begin
						ax.op = (nib == N_INCSZ) ? MID_INC : MID_DEC;
						skip  = (ax.res == 8'h00);
					end
					N_RLC, N_RRC: begin
						ax.op = (nib == N_RLC) ? MID_RLC : MID_RRC;
						upd_c = 1'b1;
					end
					N_SWAP: ax.op = MID_SWAP;
				endcase
			end
			CL_BIT: begin
				unique case (nib[3:2])
					B_CLR: begin
						ax.op = MID_BCLR;
						wr_f  = 1'b1;
					end
					B_SET: begin
						ax.op = MID_BSET;
						wr_f  = 1'b1;
					end
					B_TSTC: skip = !fval[ir_r[9:7]];
					B_TSTS: skip = fval[ir_r[9:7]];
				endcase
			end
			CL_JUMP: begin
				jump = 1'b1;
				push = !ir_r[11];
			end
			CL_LIT: begin
				ax.b = ir_r[7:0];
				wr_w = 1'b1;
				if (nib[3:2] == L_MOVE) begin
					ax.op = MID_PASS_B;
				end else if (nib[3:2] == L_RET) begin
					ax.op = MID_PASS_B;
					pop   = 1'b1;
					jump  = 1'b1;
				end else if (nib == L_IOR || nib == L_AND || nib == L_XOR) begin
					ax.op = (nib == L_IOR) ? MID_OR :
						(nib == L_AND) ? MID_AND : MID_XOR;
					upd_z = 1'b1;
				end else if (nib[3:1] == L_SUB || nib[3:1] == L_ADD) begin
					ax.op  = (nib[3:1] == L_ADD) ? MID_ADD : MID_SUB;
					upd_z  = 1'b1;
					upd_c  = 1'b1;
					upd_dc = 1'b1;
				end else begin
					wr_w = 1'b0;  // unused literal code runs as no-op
				end
			end
		endcase
		if (pop) begin
			tgt = stack_top;
		end
	end

	// ****************************************************
	// program counter and fetch pipeline
	// ****************************************************
	// the next word is always fetched while the current one executes; a
	// jump or a taken skip marks that word dead so it costs one extra cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_r    <= '0;
			ir_r    <= '0;
			flush_r <= 1'b1;
		end else if (exec) begin
			ir_r <= prog_data;
			if (!kill && jump) begin
				pc_r    <= tgt;
				flush_r <= 1'b1;
			end else begin
				pc_r    <= pc_r + 1'b1;
				flush_r <= !kill && skip;
			end
		end
	end
	assign prog_addr = pc_r;

	// ****************************************************
	// working register
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_r <= 8'h00;
		end else if (exec && !kill && wr_w) begin
			w_r <= ax.res;
		end
	end

	// ****************************************************
	// status register
	// ****************************************************
	// a direct write lands first, flag updates of the same op then win;
	// timeout and powerdown are never software writable
	always_comb begin
		status_nxt = status_r;
		if (wr_f && fa == F_STATUS) begin
			status_nxt = {ax.res[7:5], status_r[ST_TO:ST_PD], ax.res[2:0]};
		end
		if (upd_z) begin
			status_nxt[ST_Z] = (ax.res == 8'h00);
		end
		if (upd_c) begin
			status_nxt[ST_C] = ax.c;
		end
		if (upd_dc) begin
			status_nxt[ST_DC] = ax.dc;
		end
		if (watchdog_clear_op) begin
			status_nxt[ST_TO] = 1'b1;
			status_nxt[ST_PD] = 1'b1;
		end
		if (sleep_op) begin
			status_nxt[ST_TO] = 1'b1;
			status_nxt[ST_PD] = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= STATUS_RST;
		end else if (exec && !kill) begin
			status_r <= status_nxt;
		end
	end

	// ****************************************************
	// file registers and port latch
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < FILES; i++) begin
				fmem[i] <= 8'h00;
			end
		end else if (exec && !kill) begin
			if (wr_f && fa != F_STATUS && fa != F_PORT) begin
				fmem[fa] <= ax.res;
			end
			if (set_gie) begin
				fmem[F_INTCON][GIE_BIT] <= 1'b1;
			end
		end
	end
	assign gie = fmem[F_INTCON][GIE_BIT];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_latch <= 8'h00;
		end else if (exec && !kill && wr_f && fa == F_PORT) begin
			port_latch <= ax.res;
		end
	end

	// ****************************************************
	// side effects: prescaler, watchdog, standby
	// ****************************************************
	// one-pclk pulses so the timer and watchdog logic see a clean event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler_clear <= 1'b0;
			watchdog_clear  <= 1'b0;
		end else begin
			prescaler_clear <= exec && !kill && wr_f && fa == F_TIMER
				&& ctrl_r[C_PSA];
			watchdog_clear <= exec && !kill && watchdog_clear_op;
		end
	end
	// standby is left only by a software wake through ctrl
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_r <= 1'b0;
		end else if (exec && !kill && sleep_op) begin
			sleep_r <= 1'b1;
		end else if (acc_ok && is_wr && paddr == A_CTRL && pwdata[C_WAKE]) begin
			sleep_r <= 1'b0;
		end
	end
	assign standby = sleep_r;

	// ****************************************************
	// apb slave
	// ****************************************************
	// zero wait states; read data is captured in the setup cycle
	assign acc_ok  = psel && penable;
	assign is_wr   = pwrite;
	assign bad     = !(paddr == A_CTRL || paddr == A_STATE || paddr == A_PORT);
	assign pready  = 1'b1;
	assign pslverr = acc_ok && bad;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
		end else if (acc_ok && is_wr && paddr == A_CTRL) begin
			ctrl_r <= {1'b0, pwdata[C_PSA:C_RUN]};  // wake bit is write-only
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				A_CTRL:  prdata <= {29'h0, sleep_r, ctrl_r[C_PSA:C_RUN]};
				A_STATE: prdata <= {3'h0, pc_r, w_r, status_r};
				A_PORT:  prdata <= {16'h0, port_latch, port_pins};
				default: prdata <= '0;
			endcase
		end
	end
endmodule // mid_core

/* File: verification/mid_core_sva.sv */
// Purpose: port-level checks of the decoder core
// Assumes: one clock domain, pready never waits
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
module mid_core_sva import mid_pkg::*; #(
	parameter int AW = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [AW-1:0]     paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [PC_W-1:0]   prog_addr,
	input wire logic [INSN_W-1:0] prog_data,
	input wire logic [7:0]        port_pins,
	input wire logic [7:0]        port_latch,
	input wire logic              prescaler_clear,
	input wire logic              watchdog_clear,
	input wire logic              standby,
	input wire logic              gie
);
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic mapped;
	// access phase and decoded map
	assign acc    = psel && penable;
	assign mapped = paddr == AW'(A_CTRL) || paddr == AW'(A_STATE) || paddr == AW'(A_PORT);
	a_ready_const: assert property (acc |-> pready)
		else $error("pready low in access");
	a_slverr_map: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	a_slverr_idle: assert property (!acc |-> !pslverr)
		else $error("pslverr outside access");
	a_pc_stable: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
		else $error("fetch address held under four periods");
	a_wdt_pulse: assert property ($rose(watchdog_clear) |=> !watchdog_clear)
		else $error("watchdog clear not one cycle");
	a_presc_pulse: assert property ($rose(prescaler_clear) |=> !prescaler_clear)
		else $error("prescaler clear not one cycle");
	a_stby_hold: assert property (standby && $past(standby) |-> $stable(prog_addr))
		else $error("fetch moved in standby");
	a_port_read: assert property (psel && !penable && !pwrite && paddr == AW'(A_PORT)
		|=> prdata[15:0] == {$past(port_latch), $past(port_pins)})
		else $error("port read data wrong");
	a_wake_clear: assert property (acc && pwrite && paddr == AW'(A_CTRL)
		&& pwdata[C_WAKE] && standby |=> !standby)
		else $error("wake write ignored");
	c_standby: cover property ($rose(standby));
	c_wdt: cover property (watchdog_clear);
	c_presc: cover property (prescaler_clear);
	c_slverr: cover property (acc && pslverr);
endmodule // mid_core_sva

/* File: verification/mid_prog_mem.sv */
// Purpose: program memory seen by the core
// Assumes: bench loads mem before reset release
// Notes:   answers late on purpose: a fresh address gives a wrong word
`timescale 1ns/1ps
module mid_prog_mem import mid_pkg::*; (
	input  wire logic [0:0]        pclk,
	input  wire logic [PC_W-1:0]   prog_addr,
	output logic      [INSN_W-1:0] prog_data
);
	logic [INSN_W-1:0] mem [0:127];
	logic [PC_W-1:0]   last_r;
	initial foreach (mem[j]) mem[j] = 14'h0000;
	// track the address so a change can be seen
	always_ff @(posedge pclk) last_r <= prog_addr;
	// slow array: inverted data in the first cycle, core must wait
	assign prog_data = (prog_addr == last_r) ? mem[prog_addr[6:0]] : ~mem[prog_addr[6:0]];
endmodule // mid_prog_mem

/* File: verification/test_mcu_instruction_decoder.sv */
// Purpose: random programs run on the core against a bench model
// Assumes: pins constant per run, files 0x20-0x27 used
// Notes:   every run ends in standby, then is woken over apb
`timescale 1ns/1ps
module test_mcu_instruction_decoder;
	import mid_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic              prescaler_clear, watchdog_clear, standby, gie, c, dc, fz, fc, fd, sk;
	logic [7:0]        paddr, port_pins, port_latch, w, st, latch, v, r;
	logic [7:0]        fm [128];
	logic [31:0]       pwdata, prdata, rd;
	logic [PC_W-1:0]   prog_addr;
	logic [INSN_W-1:0] prog_data, i;
	logic [13:0]       prog [0:127];
	int                fail_count, check_count, seed, ecnt, stby_at, n_pc, n_wd, pc, cyc;
	int                stk [$];
	logic              mgie;
	mid_core #(.AW(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .port_pins(port_pins),
		.port_latch(port_latch), .prescaler_clear(prescaler_clear),
		.watchdog_clear(watchdog_clear), .standby(standby), .gie(gie));
	mid_prog_mem i_mem (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data));
	// ****************************************
	// clock, watchdog, monitors
	// ****************************************
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		#(8 * 20000);
		fail_count++;
		print_verdict;
	end
	// edge count since release, pulse counts
	always @(posedge pclk) begin
		if (!presetn) begin
			ecnt = 0; stby_at = -1; n_pc = 0; n_wd = 0;
		end else begin
			if (standby === 1'b1 && stby_at < 0) stby_at = ecnt;
			n_pc += prescaler_clear;
			n_wd += watchdog_clear;
			ecnt++;
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task print_verdict;
		if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one apb transfer; holds the request until pready is seen high
	task apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);  // only the watchdog ends a stuck wait
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task addc(input logic [7:0] a, input logic [7:0] b, input logic ci);
		{c, r} = {1'b0, a} + {1'b0, b} + 9'(ci);
		dc = (5'(a[3:0]) + 5'(b[3:0]) + 5'(ci)) > 5'h0F;
		fz = 1; fc = 1; fd = 1;
	endtask
	task wr_file(input logic [6:0] a, input logic [7:0] d);
		fm[a] = d;
		if (a == F_PORT) latch = d;
	endtask
	// integer model: executes prog until the standby instruction
	task run_model;
		w = 0; st = STATUS_RST; pc = 0; cyc = 0; mgie = 0; latch = 0; stk = {};
		foreach (fm[j]) fm[j] = 0;
		for (int n = 0; n < 400; n++) begin
			i = prog[pc]; pc++; cyc++; sk = 0; fz = 0; fc = 0; fd = 0;
			v = (i[6:0] == F_PORT) ? port_pins : fm[i[6:0]];
			c = st[ST_C]; r = w;
			if (i == OP_SLEEP) begin
				st[ST_TO] = 1; st[ST_PD] = 0;
				break;
			end else if (i == OP_WATCHDOG_CLEAR_OP) st[4:3] = 2'h3;
			else if (i == OP_INTERRUPT_RETURN || i == OP_RETURN) begin
				pc = stk.pop_back(); mgie |= i[0]; cyc++;
			end else if (i[13:12] == CL_JUMP) begin
				if (!i[11]) stk.push_back(pc);
				pc = i[10:0]; cyc++;
			end else if (i[13:12] == CL_BIT) begin
				case (i[11:10])
					B_CLR: v[i[9:7]] = 0;
					B_SET: v[i[9:7]] = 1;
					B_TSTC: sk = !v[i[9:7]];
					default: sk = v[i[9:7]];
				endcase
				if (!i[11]) wr_file(i[6:0], v);
			end else if (i[13:12] == CL_LIT) begin
				casez (i[11:8])
					4'b00??: r = i[7:0];
					4'b01??: begin r = i[7:0]; pc = stk.pop_back(); cyc++; end
					L_IOR: begin r = w | i[7:0]; fz = 1; end
					L_AND: begin r = w & i[7:0]; fz = 1; end
					L_XOR: begin r = w ^ i[7:0]; fz = 1; end
					4'b110?: addc(i[7:0], ~w, 1'b1);
					default: addc(i[7:0], w, 1'b0);
				endcase
				w = r;
			end else begin
				fz = 1;
				case (i[11:8])
					N_MOVWF: begin r = w; fz = 0; end
					N_CLR: r = 0;
					N_SUB: addc(v, ~w, 1'b1);
					N_DEC: r = v - 1;
					N_IOR: r = w | v;
					N_AND: r = w & v;
					N_XOR: r = w ^ v;
					N_ADD: addc(v, w, 1'b0);
					N_MOVF: r = v;
					N_COM: r = ~v;
					N_INC: r = v + 1;
					N_RRC: begin r = {c, v[7:1]}; c = v[0]; fz = 0; fc = 1; end
					N_RLC: begin r = {v[6:0], c}; c = v[7]; fz = 0; fc = 1; end
					N_SWAP: begin r = {v[3:0], v[7:4]}; fz = 0; end
					default: begin r = i[10] ? v + 1 : v - 1; sk = r == 0; fz = 0; end
				endcase
				if (i[7]) wr_file(i[6:0], r);
				else w = r;
			end
			if (fz) st[ST_Z] = r == 8'h00;
			if (fc) st[ST_C] = c;
			if (fd) st[ST_DC] = dc;
			if (sk) begin pc++; cyc++; end
		end
	endtask
	// program: calls, random body, timer and port writes, standby
	task gen;
		logic [3:0] nb;
		foreach (prog[j]) prog[j] = 14'h0000;
		prog[1] = 14'h2064;
		prog[2] = 14'h2068;
		for (int j = 3; j < 27; j++) begin
			nb = $random(seed);
			case ($random(seed) & 3)
				0, 1: prog[j] = {CL_BYTE, nb, nb == 0 || 1'($random(seed)), 4'h4, 3'($random(seed))};
				2: prog[j] = {CL_BIT, nb, 1'($random(seed)), 4'h4, 3'($random(seed))};
				default: begin
					if (nb[3:2] == 2'h1 || nb == 4'hB) nb = nb ^ 4'h8;
					prog[j] = {CL_LIT, nb, 8'($random(seed))};
				end
			endcase
		end
		prog[28] = 14'h0081;
		prog[29] = 14'h0886;
		prog[30] = OP_WATCHDOG_CLEAR_OP;
		prog[31] = OP_SLEEP;
		prog[32] = 14'h2820;
		prog[100] = {6'h34, 8'($random(seed))};
		prog[104] = 14'h206C;
		prog[105] = OP_INTERRUPT_RETURN;
		prog[108] = OP_RETURN;
		foreach (prog[j]) i_mem.mem[j] = prog[j];
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seed = 17355; fail_count = 0; check_count = 0; presetn = 0; psel = 0; penable = 0;
		pwrite = 0; paddr = 0; pwdata = 0; port_pins = 0;
		repeat (4) begin
			@(posedge pclk);
			presetn <= 0;
			port_pins <= $random(seed);
			gen;
			repeat (16) @(posedge pclk);
			presetn <= 1;
			run_model;
			apb(A_CTRL, 1, 32'h00000003);
			for (int n = 0; n < 3000 && standby !== 1'b1; n++) @(posedge pclk);
			apb(A_STATE, 0, 32'h00000000);
			chk(stby_at, 4 * (1 + cyc), "standby delay");
			chk(rd[7:0], st, "status");
			chk(rd[4:3], st[4:3], "timeout and powerdown");
			chk(rd[15:8], w, "accumulator");
			apb(A_PORT, 0, 32'h00000000);
			chk(rd[15:0], {latch, port_pins}, "port");
			chk(port_latch, latch, "latch");
			chk(gie, mgie, "enable");
			chk({n_pc, n_wd}, 64'h0000000100000001, "pulses");
			apb(8'h0C, 0, 32'h00000000);
			chk({err, rd}, 33'h100000000, "unmapped");
			apb(A_CTRL, 1, 32'h00000007);
			apb(A_CTRL, 0, 32'h00000000);
			chk(rd[2:0], 3'h3, "wake");
		end
		print_verdict;
	end
endmodule // test_mcu_instruction_decoder

bind mid_core mid_core_sva #(.AW(AW)) i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
	.port_pins(port_pins), .port_latch(port_latch), .prescaler_clear(prescaler_clear),
	.watchdog_clear(watchdog_clear), .standby(standby), .gie(gie));
